// File: logic/port_io_pkg.sv
// Shared constants and carriers for the quasi-bidirectional port block.
// Assumes a single core clock; the core issues one port request at a time.
`default_nettype none

package port_io_pkg;

  // Clock and machine-cycle timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_DIV = 12;
  localparam int MCYC_NS = CLK_PERIOD_NS * OSC_DIV;
  localparam int MCYC_CLKS = (MCYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map (special-function addresses)
  localparam logic [7:0] THIRD_PORT_ADDR = 8'hB0;
  localparam logic [7:0] FOURTH_PORT_ADDR = 8'hD8;
  localparam int FOURTH_PORT_W = 4;
  localparam logic [7:0] THIRD_PORT_RST = 8'hFF;
  localparam logic [FOURTH_PORT_W-1:0] FOURTH_PORT_RST = 4'hF;
  localparam logic [3:0] FOURTH_UNUSED_RD = 4'h0;

  // First-port pin roles
  localparam int FP_TIMER_C_CNT = 0;
  localparam int FP_TIMER_C_AUX = 1;
  localparam int FP_PWM_BASE = 3;
  localparam int PWM_CHANS = 5;

  // Third-port pin roles
  localparam int TP_SER_DATA = 0;
  localparam int TP_SER_CLK = 1;
  localparam int TP_IRQ_ZERO = 2;
  localparam int TP_IRQ_ONE = 3;
  localparam int TP_TIMER_A = 4;
  localparam int TP_TIMER_B = 5;
  localparam int TP_WR_STROBE = 6;
  localparam int TP_RD_STROBE = 7;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_AND = 4'h2,
    OP_OR = 4'h3,
    OP_XOR = 4'h4,
    OP_JBC = 4'h5,
    OP_CPL = 4'h6,
    OP_INC = 4'h7,
    OP_DEC = 4'h8,
    OP_DJNZ = 4'h9,
    OP_MOVC = 4'hA,
    OP_CLR = 4'hB,
    OP_SETB = 4'hC
  } port_op_t;

  typedef struct packed {
    port_op_t op;
    logic [7:0] addr;
    logic [7:0] operand;
    logic [2:0] bit_idx;
    logic carry;
  } port_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic bit_val;
    logic nonzero;
    logic hit;
  } port_rsp_t;

  typedef struct packed {
    logic sync_mode;
    logic txd;
    logic shift_clk;
    logic data_out;
  } serial_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } req_state_t;

endpackage : port_io_pkg

`default_nettype wire

// File: logic/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the inputs are plain levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Idle pins read high through the weak pull-up
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : pin_sync

`default_nettype wire

// File: logic/mcyc_gen.sv
// Machine-cycle tick: one core clock pulse every oscillator-divide period.
// Assumes the core clock is the oscillator clock.
`timescale 1ns/1ps
`default_nettype none

module mcyc_gen #(
  parameter int DIV = port_io_pkg::MCYC_CLKS
) (
  input wire logic core_clk,
  input wire logic rstn,
  output logic tick
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == 8'(DIV - 1));
    nxt_cnt = nxt_tick ? 8'h00 : cnt_ff + 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : mcyc_gen

`default_nettype wire

// File: logic/quasi_bidir_port_io.sv
// Quasi-bidirectional third and fourth ports, shared-pin routing of first and
// third ports, and the core's port read / read-modify-write access path.
// Assumes the core holds a request until req_ready and issues one at a time.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RQ1] First-port pins 0 and 1 feed the third timer's count and aux inputs.
// [RQ2] First-port pins 3..7 carry PWM channels zero..four in order.
// [RQ3] Third-port bit 0 pulls its pin low; bit 1 releases to pull-up.
// [RQ4] Software sets a third-port bit before using it as input or alternate.
// [RQ5] Third-port pin 0: receive data async, bidirectional data synchronous.
// [RQ6] Third-port pin 1: transmit data async, shift clock out synchronous.
// [RQ7] Third-port pins 2,3 feed external irqs and timer gate inputs.
// [RQ8] Third-port pins 4,5 are count inputs of the first two timers.
// [RQ9] External memory strobes drive write on pin 6, read on pin 7.
// [RQ10] Fourth port has four lines at address D8, upper bits unused.
// [RQ11] Fourth-port register bits 3..0 set matching pin output levels.
// [RQ12] Read-modify-write reads the latch, modifies, writes back to latch.
// [RQ13] Plain port reads return the sampled pin levels.
// [RQ14] AND, OR, XOR, JBC, CPL, INC, DEC, DJNZ, MOV C, CLR, SETB are RMW.
// [RQ15] New port value reaches the latch in the instruction's final machine cycle.
// [RQ16] External inputs must stay stable longer than one machine cycle.
// [RQ17] Reset sets every implemented port register bit to one.
// [RQ18] Fourth-port upper bits ignore writes and read as zero.
module quasi_bidir_port_io (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire port_io_pkg::port_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output port_io_pkg::port_rsp_t rsp,
  input wire logic [7:0] first_port_latch,
  input wire logic [port_io_pkg::PWM_CHANS-1:0] pwm_en,
  input wire logic [port_io_pkg::PWM_CHANS-1:0] pwm_level,
  input wire port_io_pkg::serial_pins_t ser,
  input wire logic xmem_wr_active,
  input wire logic xmem_rd_active,
  input wire logic [7:0] first_port_pin_in,
  output logic [7:0] first_port_pin_out,
  output logic [7:0] first_port_pin_oe_n,
  input wire logic [7:0] third_port_pin_in,
  output logic [7:0] third_port_pin_out,
  output logic [7:0] third_port_pin_oe_n,
  input wire logic [port_io_pkg::FOURTH_PORT_W-1:0] fourth_port_pin_in,
  output logic [port_io_pkg::FOURTH_PORT_W-1:0] fourth_port_pin_out,
  output logic [port_io_pkg::FOURTH_PORT_W-1:0] fourth_port_pin_oe_n,
  output logic [7:0] third_port_latch_q,
  output logic ser_rx_data,
  output logic timer_c_count_input,
  output logic timer_c_aux_input,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic timer_a_gate,
  output logic timer_b_gate,
  output logic timer_a_count_input,
  output logic timer_b_count_input
);

  localparam int SAMPLE_W = 16 + port_io_pkg::FOURTH_PORT_W;
  localparam int FW = port_io_pkg::FOURTH_PORT_W;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  function automatic logic is_rmw(input port_io_pkg::port_op_t op);
    is_rmw = (op != port_io_pkg::OP_READ) && (op != port_io_pkg::OP_WRITE);
  endfunction : is_rmw

  function automatic logic [7:0] modify(input port_io_pkg::port_op_t op, input logic [7:0] old,
                                        input logic [7:0] operand, input logic [2:0] idx,
                                        input logic carry);
    logic [7:0] m;
    m = bit_mask(idx);
    case (op)
      port_io_pkg::OP_WRITE: modify = operand;
      port_io_pkg::OP_AND: modify = old & operand;
      port_io_pkg::OP_OR: modify = old | operand;
      port_io_pkg::OP_XOR: modify = old ^ operand;
      port_io_pkg::OP_JBC: modify = old & ~m;
      port_io_pkg::OP_CLR: modify = old & ~m;
      port_io_pkg::OP_CPL: modify = old ^ m;
      port_io_pkg::OP_INC: modify = old + 8'h01;
      port_io_pkg::OP_DEC: modify = old - 8'h01;
      port_io_pkg::OP_DJNZ: modify = old - 8'h01;
      port_io_pkg::OP_MOVC: modify = carry ? (old | m) : (old & ~m);
      port_io_pkg::OP_SETB: modify = old | m;
      default: modify = old;
    endcase
  endfunction : modify

  logic mcyc_tick;
  logic [SAMPLE_W-1:0] pin_sync_q;

  mcyc_gen #(.DIV(port_io_pkg::MCYC_CLKS)) u_mcyc (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(mcyc_tick)
  );

  pin_sync #(.WIDTH(SAMPLE_W)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in({fourth_port_pin_in, third_port_pin_in, first_port_pin_in}),
    .sync_out(pin_sync_q)
  );

  // Pin sampling, once per machine cycle
  logic [SAMPLE_W-1:0] sample_ff;
  logic [SAMPLE_W-1:0] nxt_sample;
  logic [7:0] fp_sample;
  logic [7:0] tp_sample;
  logic [FW-1:0] qp_sample;

  // [RQ16] Sample each machine cycle
  always_comb begin
    nxt_sample = mcyc_tick ? pin_sync_q : sample_ff;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sample_ff <= '1;
    end else begin
      sample_ff <= nxt_sample;
    end
  end

  assign fp_sample = sample_ff[7:0];
  assign tp_sample = sample_ff[15:8];
  assign qp_sample = sample_ff[SAMPLE_W-1:16];

  // Request handling and port latches
  port_io_pkg::req_state_t state_ff, nxt_state;
  port_io_pkg::port_req_t req_ff, nxt_req;
  logic [7:0] result_ff, nxt_result;
  logic [7:0] rd_src_ff, nxt_rd_src;
  logic [7:0] third_latch_ff, nxt_third_latch;
  logic [FW-1:0] fourth_latch_ff, nxt_fourth_latch;
  logic req_ready_ff, nxt_req_ready;
  logic rsp_valid_ff, nxt_rsp_valid;
  port_io_pkg::port_rsp_t rsp_ff, nxt_rsp;
  logic hit_third, hit_fourth;
  logic [7:0] latch_view, pin_view;

  always_comb begin
    hit_third = (req.addr == port_io_pkg::THIRD_PORT_ADDR);
    hit_fourth = (req.addr == port_io_pkg::FOURTH_PORT_ADDR);
    // [RQ18] Unused upper bits read zero
    latch_view = hit_third ? third_latch_ff : {port_io_pkg::FOURTH_UNUSED_RD, fourth_latch_ff};
    pin_view = hit_third ? tp_sample : {port_io_pkg::FOURTH_UNUSED_RD, qp_sample};
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_result = result_ff;
    nxt_rd_src = rd_src_ff;
    nxt_third_latch = third_latch_ff;
    nxt_fourth_latch = fourth_latch_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp = rsp_ff;
    case (state_ff)
      port_io_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_req = req;
          // [RQ12] Modify source is the latch
          // [RQ13] Plain reads see the pins
          nxt_rd_src = (req.op == port_io_pkg::OP_READ) ? pin_view : latch_view;
          // [RQ14] Register-sourced modify set
          nxt_result = modify(req.op, latch_view, req.operand, req.bit_idx, req.carry);
          nxt_state = port_io_pkg::ST_WAIT;
        end
      end
      port_io_pkg::ST_WAIT: begin
        // [RQ15] Update lands at the machine-cycle boundary
        if (mcyc_tick) begin
          nxt_state = port_io_pkg::ST_IDLE;
          nxt_rsp_valid = 1'b1;
          nxt_rsp.hit = (req_ff.addr == port_io_pkg::THIRD_PORT_ADDR) ||
                        (req_ff.addr == port_io_pkg::FOURTH_PORT_ADDR);
          nxt_rsp.rdata = nxt_rsp.hit && (req_ff.op != port_io_pkg::OP_WRITE) ? rd_src_ff : 8'h00;
          nxt_rsp.bit_val = rd_src_ff[req_ff.bit_idx];
          nxt_rsp.nonzero = (result_ff != 8'h00);
          if (req_ff.op != port_io_pkg::OP_READ) begin
            if (req_ff.addr == port_io_pkg::THIRD_PORT_ADDR) begin
              nxt_third_latch = result_ff;
            end
            // [RQ10] Fourth port decoded at D8
            // [RQ18] Upper write bits dropped
            if (req_ff.addr == port_io_pkg::FOURTH_PORT_ADDR) begin
              nxt_fourth_latch = result_ff[FW-1:0];
            end
          end
        end
      end
      default: begin
        nxt_state = port_io_pkg::ST_IDLE;
      end
    endcase
    nxt_req_ready = (nxt_state == port_io_pkg::ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= port_io_pkg::ST_IDLE;
      req_ff <= '0;
      result_ff <= 8'h00;
      rd_src_ff <= 8'h00;
      // [RQ17] All port bits start as inputs
      third_latch_ff <= port_io_pkg::THIRD_PORT_RST;
      fourth_latch_ff <= port_io_pkg::FOURTH_PORT_RST;
      req_ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      result_ff <= nxt_result;
      rd_src_ff <= nxt_rd_src;
      third_latch_ff <= nxt_third_latch;
      fourth_latch_ff <= nxt_fourth_latch;
      req_ready_ff <= nxt_req_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_ff <= nxt_rsp;
    end
  end

  // Pin drive: a 1 releases to the pull-up, a 0 pulls low
  logic [7:0] fp_drive_ff, nxt_fp_drive;
  logic [7:0] tp_drive_ff, nxt_tp_drive;
  logic [FW-1:0] qp_drive_ff, nxt_qp_drive;
  logic [7:0] tp_alt;

  always_comb begin
    nxt_fp_drive = first_port_latch;
    // [RQ2] PWM channels on first-port pins 3..7
    for (int ch = 0; ch < port_io_pkg::PWM_CHANS; ch++) begin
      if (pwm_en[ch] && !pwm_level[ch]) begin
        nxt_fp_drive[port_io_pkg::FP_PWM_BASE + ch] = 1'b0;
      end
    end
    tp_alt = 8'hFF;
    // [RQ5] Synchronous mode drives data; async leaves receive released
    tp_alt[port_io_pkg::TP_SER_DATA] = ser.sync_mode ? ser.data_out : 1'b1;
    // [RQ6] Shift clock or transmit data
    tp_alt[port_io_pkg::TP_SER_CLK] = ser.sync_mode ? ser.shift_clk : ser.txd;
    // [RQ9] External memory strobes, active low on the pin
    tp_alt[port_io_pkg::TP_WR_STROBE] = !xmem_wr_active;
    tp_alt[port_io_pkg::TP_RD_STROBE] = !xmem_rd_active;
    // [RQ3] Latch low pulls pin low; alternate only pulls when latch high
    nxt_tp_drive = third_latch_ff & tp_alt;
    // [RQ11] Fourth-port bits set pin levels
    nxt_qp_drive = fourth_latch_ff;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fp_drive_ff <= 8'hFF;
      tp_drive_ff <= port_io_pkg::THIRD_PORT_RST;
      qp_drive_ff <= port_io_pkg::FOURTH_PORT_RST;
    end else begin
      fp_drive_ff <= nxt_fp_drive;
      tp_drive_ff <= nxt_tp_drive;
      qp_drive_ff <= nxt_qp_drive;
    end
  end

  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;
  // Output value is the level; the enable is active only when pulling low
  assign first_port_pin_out = fp_drive_ff;
  assign first_port_pin_oe_n = fp_drive_ff;
  assign third_port_pin_out = tp_drive_ff;
  assign third_port_pin_oe_n = tp_drive_ff;
  assign fourth_port_pin_out = qp_drive_ff;
  assign fourth_port_pin_oe_n = qp_drive_ff;
  assign third_port_latch_q = third_latch_ff;
  // [RQ1] Third timer inputs
  assign timer_c_count_input = fp_sample[port_io_pkg::FP_TIMER_C_CNT];
  assign timer_c_aux_input = fp_sample[port_io_pkg::FP_TIMER_C_AUX];
  // [RQ5] Receive data from pin 0
  assign ser_rx_data = tp_sample[port_io_pkg::TP_SER_DATA];
  // [RQ7] Interrupts and timer gates share pins 2 and 3
  assign ext_irq_zero = tp_sample[port_io_pkg::TP_IRQ_ZERO];
  assign ext_irq_one = tp_sample[port_io_pkg::TP_IRQ_ONE];
  assign timer_a_gate = tp_sample[port_io_pkg::TP_IRQ_ZERO];
  assign timer_b_gate = tp_sample[port_io_pkg::TP_IRQ_ONE];
  // [RQ8] Timer count inputs
  assign timer_a_count_input = tp_sample[port_io_pkg::TP_TIMER_A];
  assign timer_b_count_input = tp_sample[port_io_pkg::TP_TIMER_B];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  reset_latches_a: assert property ($rose(rstn) |-> third_latch_ff == 8'hFF && fourth_latch_ff == 4'hF) // [RQ17]
    else $error("port latches not all ones after reset");
  third_drive_a: assert property (tp_drive_ff == ($past(third_latch_ff) & $past(tp_alt))) // [RQ3]
    else $error("third port pin drive does not follow latch");
  fourth_drive_a: assert property (fourth_port_pin_oe_n == $past(fourth_latch_ff)) // [RQ11]
    else $error("fourth port pin does not follow latch");
  upper_zero_a: assert property (rsp_valid_ff && req_ff.addr == 8'hD8 |-> rsp_ff.rdata[7:4] == 4'h0) // [RQ18]
    else $error("fourth port upper bits not zero");
  rmw_source_a: assert property (rsp_valid_ff && is_rmw(req_ff.op) && req_ff.addr == 8'hB0
      |-> rsp_ff.rdata == $past(third_latch_ff)) // [RQ12]
    else $error("modify did not read the latch");
  pin_read_a: assert property (state_ff == port_io_pkg::ST_IDLE && req_valid && req.op == port_io_pkg::OP_READ
      && req.addr == 8'hB0 |=> rd_src_ff == $past(tp_sample)) // [RQ13]
    else $error("plain read did not see pins");
  inc_result_a: assert property (rsp_valid_ff && req_ff.op == port_io_pkg::OP_INC && req_ff.addr == 8'hB0
      |-> third_latch_ff == rsp_ff.rdata + 8'h01) // [RQ14]
    else $error("increment result wrong");
  latch_timing_a: assert property ($changed(third_latch_ff) |-> $past(mcyc_tick) && rsp_valid_ff) // [RQ15]
    else $error("latch changed off machine-cycle boundary");
  req_bound_a: assert property (state_ff == port_io_pkg::ST_IDLE && req_valid |-> ##[2:13] rsp_valid_ff) // [RQ15]
    else $error("request not answered within a machine cycle");
  pwm_pin_a: assert property (pwm_en[0] && !pwm_level[0] |=> !first_port_pin_oe_n[3]) // [RQ2]
    else $error("pwm channel zero not on pin 3");
  wr_strobe_a: assert property (xmem_wr_active |=> !third_port_pin_oe_n[6]) // [RQ9]
    else $error("write strobe not driven");
  shift_clk_a: assert property (ser.sync_mode && third_latch_ff[1]
      |=> third_port_pin_out[1] == $past(ser.shift_clk)) // [RQ6]
    else $error("shift clock not on pin 1");

  rmw_cov: cover property (rsp_valid_ff && is_rmw(req_ff.op) && rsp_ff.hit);
  read_cov: cover property (rsp_valid_ff && req_ff.op == port_io_pkg::OP_READ && rsp_ff.hit);
  fourth_wr_cov: cover property (rsp_valid_ff && req_ff.op == port_io_pkg::OP_WRITE && req_ff.addr == 8'hD8);

endmodule : quasi_bidir_port_io

`default_nettype wire

// File: sim/pin_load.sv
// External circuitry on quasi-bidirectional pins: weak pull-up plus an optional low drive.
// Assumes oe_n low means the block itself pulls the pin low.
`timescale 1ns/1ps
`default_nettype none

module pin_load #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] ext_low,
  output logic [W-1:0] pin_level
);
  logic [W-1:0] drv_ff;

  // levels held whole cycles
  // Drive is taken on the clock so no sliver pulse ever reaches the pin
  always_ff @(posedge core_clk) drv_ff <= ext_low;

  // Pull-up wins unless either side sinks the line
  assign pin_level = pin_oe_n & ~drv_ff;
endmodule : pin_load

`default_nettype wire

// File: sim/quasi_bidir_port_io_tb.sv
// Self-checking bench for the port block: requests, pin routing and sampling.
// Assumes the pin_load model stands on every port and the core holds requests.
`timescale 1ns/1ps
`default_nettype none

module quasi_bidir_port_io_tb;
  logic core_clk, rstn, req_valid, req_ready, rsp_valid, wr_act, rd_act;
  port_io_pkg::port_req_t req;
  port_io_pkg::port_rsp_t rsp;
  port_io_pkg::serial_pins_t ser;
  logic [7:0] fp_latch, fp_in, fp_out, fp_oe_n, tp_in, tp_out, tp_oe_n, tp_q, ext1, ext3, t3;
  logic [4:0] pwm_en, pwm_level;
  logic [3:0] qp_in, qp_out, qp_oe_n, ext4, t4;
  logic rx, tc_cnt, tc_aux, irq0, irq1, ga, gb, ca, cb;
  logic [31:0] rng;
  int n_fail, n_tests;
  typedef struct packed {logic [7:0] rdata; logic bv, nz, dj, hit; logic [7:0] lat;} note_t;
  note_t q[$];
  note_t m;

  quasi_bidir_port_io uut (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .first_port_latch(fp_latch), .pwm_en(pwm_en),
    .pwm_level(pwm_level), .ser(ser), .xmem_wr_active(wr_act), .xmem_rd_active(rd_act),
    .first_port_pin_in(fp_in), .first_port_pin_out(fp_out), .first_port_pin_oe_n(fp_oe_n),
    .third_port_pin_in(tp_in), .third_port_pin_out(tp_out), .third_port_pin_oe_n(tp_oe_n),
    .fourth_port_pin_in(qp_in), .fourth_port_pin_out(qp_out), .fourth_port_pin_oe_n(qp_oe_n),
    .third_port_latch_q(tp_q), .ser_rx_data(rx), .timer_c_count_input(tc_cnt),
    .timer_c_aux_input(tc_aux), .ext_irq_zero(irq0), .ext_irq_one(irq1), .timer_a_gate(ga),
    .timer_b_gate(gb), .timer_a_count_input(ca), .timer_b_count_input(cb)
  );
  pin_load #(.W(8)) load1 (.core_clk(core_clk), .pin_oe_n(fp_oe_n), .ext_low(ext1), .pin_level(fp_in));
  pin_load #(.W(8)) load3 (.core_clk(core_clk), .pin_oe_n(tp_oe_n), .ext_low(ext3), .pin_level(tp_in));
  pin_load #(.W(4)) load4 (.core_clk(core_clk), .pin_oe_n(qp_oe_n), .ext_low(ext4), .pin_level(qp_in));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  // Third-port drive: latch ANDed with whatever alternate function owns the pin
  function automatic logic [7:0] tp_exp();
    logic [7:0] a;
    a = 8'hFF;
    a[0] = ser.sync_mode ? ser.data_out : 1'b1;
    a[1] = ser.sync_mode ? ser.shift_clk : ser.txd;
    a[6] = ~wr_act;
    a[7] = ~rd_act;
    return t3 & a;
  endfunction : tp_exp

  function automatic logic [7:0] rmw(input port_io_pkg::port_op_t op, input logic [7:0] o,
                                     input logic [7:0] v, input logic [2:0] i, input logic c);
    logic [7:0] r;
    r = o;
    case (op)
      port_io_pkg::OP_WRITE: r = v;
      port_io_pkg::OP_AND: r = o & v;
      port_io_pkg::OP_OR: r = o | v;
      port_io_pkg::OP_XOR: r = o ^ v;
      port_io_pkg::OP_JBC, port_io_pkg::OP_CLR: r[i] = 1'b0;
      port_io_pkg::OP_CPL: r[i] = ~o[i];
      port_io_pkg::OP_INC: r = o + 8'h01;
      port_io_pkg::OP_DEC, port_io_pkg::OP_DJNZ: r = o - 8'h01;
      port_io_pkg::OP_MOVC: r[i] = c;
      port_io_pkg::OP_SETB: r[i] = 1'b1;
      default: r = o;
    endcase
    return r;
  endfunction : rmw

  // One request: note the answer, hold until taken, wait for it, then check the pins
  task automatic issue(input port_io_pkg::port_op_t op, input logic [7:0] a, input logic [7:0] v,
                       input logic [2:0] i, input logic c);
    note_t n;
    logic [7:0] old, r;
    logic h3, h4;
    int k;
    h3 = (a == port_io_pkg::THIRD_PORT_ADDR);
    h4 = (a == port_io_pkg::FOURTH_PORT_ADDR);
    old = h3 ? t3 : {4'h0, t4};
    r = rmw(op, old, v, i, c);
    n.rdata = (op == port_io_pkg::OP_READ) ? (h3 ? tp_exp() & ~ext3 : {4'h0, t4 & ~ext4}) : old;
    // Bit report follows the read source, even where rdata is forced to zero
    n.bv = n.rdata[i];
    if (op == port_io_pkg::OP_WRITE || !(h3 || h4))
      n.rdata = 8'h00;
    n.dj = (op == port_io_pkg::OP_DJNZ) && h3;
    n.nz = (r != 8'h00);
    n.hit = h3 | h4;
    if (op != port_io_pkg::OP_READ && h3)
      t3 = r;
    if (op != port_io_pkg::OP_READ && h4)
      t4 = r[3:0];
    n.lat = t3;
    q.push_back(n);
    @(negedge core_clk);
    req = {op, a, v, i, c};
    req_valid = 1'b1;
    for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge core_clk);
    if (k >= 40) k = 80;
    @(negedge core_clk);
    req_valid = 1'b0;
    for (k = k; k < 80 && q.size() > 0; k++) @(negedge core_clk);
    if (k >= 80) begin
      chk("handshake timeout", 0, 1);
      test_done();
    end
    @(negedge core_clk);
    chk("third pins", tp_out, tp_exp());
    chk("third oe_n", tp_oe_n, tp_exp());
    chk("fourth pins", {qp_oe_n, qp_out}, {t4, t4});
  endtask : issue

  task automatic reset_chk();
    t3 = 8'hFF;
    t4 = 4'hF;
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk("latch after reset", tp_q, 8'hFF);
    chk("third after reset", tp_out, tp_exp());
    chk("fourth after reset", qp_out, 4'hF);
    chk("ready after reset", req_ready, 1'b1);
  endtask : reset_chk

  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0)
        chk("unexpected answer", 0, 1);
      else begin
        m = q.pop_front();
        chk("rdata", rsp.rdata, m.rdata);
        chk("bit_val", rsp.bit_val, m.bv);
        if (m.dj)
          chk("nonzero", rsp.nonzero, m.nz);
        chk("hit", rsp.hit, m.hit);
        chk("latch at answer", tp_q, m.lat);
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin : main
    int k;
    logic [31:0] r;
    logic [7:0] l1, l3;
    rng = 32'h17;
    n_fail = 0;
    n_tests = 0;
    {rstn, req_valid, wr_act, rd_act} = 4'h0;
    req = '0;
    ser = 4'h7;
    {fp_latch, pwm_en, pwm_level} = {8'hFF, 5'h00, 5'h1F};
    {ext1, ext3, ext4} = 20'h0;
    reset_chk();
    // Wrap-around and zero-result edges first
    issue(port_io_pkg::OP_INC, port_io_pkg::THIRD_PORT_ADDR, 8'h00, 3'h0, 1'b0);
    issue(port_io_pkg::OP_DEC, port_io_pkg::THIRD_PORT_ADDR, 8'h00, 3'h0, 1'b0);
    issue(port_io_pkg::OP_WRITE, port_io_pkg::THIRD_PORT_ADDR, 8'h01, 3'h0, 1'b0);
    issue(port_io_pkg::OP_DJNZ, port_io_pkg::THIRD_PORT_ADDR, 8'h00, 3'h0, 1'b0);
    issue(port_io_pkg::OP_DJNZ, port_io_pkg::THIRD_PORT_ADDR, 8'h00, 3'h0, 1'b0);
    for (k = 0; k < 24; k++) begin
      r = xs();
      issue(port_io_pkg::port_op_t'(1 + k % 12), port_io_pkg::THIRD_PORT_ADDR, r[7:0], r[10:8], r[11]);
      issue(port_io_pkg::port_op_t'(1 + k % 12), port_io_pkg::FOURTH_PORT_ADDR, r[19:12], r[22:20], r[23]);
    end
    // Unmapped places take nothing and answer zero
    issue(port_io_pkg::OP_WRITE, 8'h90, 8'h00, 3'h0, 1'b0);
    issue(port_io_pkg::OP_OR, 8'h00, 8'hFF, 3'h0, 1'b0);
    issue(port_io_pkg::OP_WRITE, port_io_pkg::THIRD_PORT_ADDR, 8'hFF, 3'h0, 1'b0);
    for (k = 0; k < 8; k++) begin
      r = xs();
      if (k > 3)
        issue(port_io_pkg::OP_WRITE, port_io_pkg::THIRD_PORT_ADDR, r[31:24], 3'h0, 1'b0);
      @(negedge core_clk);
      {ser, wr_act, rd_act, pwm_en, pwm_level, fp_latch} = r[23:0];
      r = xs();
      {ext1, ext3, ext4} = r[19:0];
      // Held well past one machine cycle
      repeat (20) @(negedge core_clk);
      l1 = fp_latch & ~{pwm_en & ~pwm_level, 3'b000};
      l3 = tp_exp() & ~ext3;
      chk("first pins", fp_out, l1);
      chk("first oe_n", fp_oe_n, l1);
      chk("third pins alt", tp_out, tp_exp());
      l1 = l1 & ~ext1;
      chk("timer c inputs", {tc_aux, tc_cnt}, l1[1:0]);
      chk("serial rx", rx, l3[0]);
      chk("irq inputs", {irq1, irq0}, l3[3:2]);
      chk("gate inputs", {gb, ga}, l3[3:2]);
      chk("count inputs", {cb, ca}, l3[5:4]);
      issue(port_io_pkg::OP_READ, port_io_pkg::THIRD_PORT_ADDR, 8'h00, r[22:20], 1'b0);
      issue(port_io_pkg::OP_READ, port_io_pkg::FOURTH_PORT_ADDR, 8'h00, r[25:23], 1'b0);
      issue(port_io_pkg::OP_OR, port_io_pkg::THIRD_PORT_ADDR, 8'h00, r[28:26], 1'b0);
    end
    ser = 4'h7;
    {wr_act, rd_act} = 2'b00;
    reset_chk();
    test_done();
  end
endmodule : quasi_bidir_port_io_tb

`default_nettype wire
